// *** hw/asc_pkg.sv ***
package asc_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int MEM_WORDS = 65536;
    localparam int CLK_MHZ = 50;
    localparam int CLK_PERIOD_NS = 20;
    localparam int SUPPLY_SETTLE_US = 100;
    localparam int SUPPLY_SETTLE_CYC = SUPPLY_SETTLE_US * CLK_MHZ;
    localparam int READ_CYCLE_NS = 12;
    localparam int READ_CYCLE_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_PULSE_NS = 8;
    localparam int WE_PULSE_CYC = (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_NS = 12;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 16;
    localparam logic [1:0] BYTE_SEL_RST = 2'h3;

    typedef enum logic [2:0] {
        ASC_POWERUP = 3'h0,
        ASC_IDLE = 3'h1,
        ASC_WR_SETUP = 3'h2,
        ASC_WR_PULSE = 3'h3,
        ASC_WR_END = 3'h4,
        ASC_RD_ADDR = 3'h5,
        ASC_RD_WAIT = 3'h6,
        ASC_RECOVER = 3'h7
    } asc_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] byte_en;
        logic write;
    } asc_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chip_select_n;
        logic write_strobe_n;
        logic output_drive_n;
        logic low_byte_sel_n;
        logic high_byte_sel_n;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } asc_pins_t;
endpackage

// *** hw/asc_ctrl.sv ***
`timescale 1ns/10ps
// What this block does
// - Write happens only with chip select and write strobe both low.
// - Read needs chip select and output drive low, write strobe high.
// - Wait at least 100 microseconds after supply up before first access.
// - Retention needs chip deselected; resume after one read-cycle time.
// - Write ends at first rising edge of select, byte select or strobe.
// - Address valid no later than chip select falling for reads.
module asc_ctrl #(
    parameter int SETTLE_CYC = asc_pkg::SUPPLY_SETTLE_CYC
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire asc_pkg::asc_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [asc_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic retention_req,
    output logic in_retention,
    input wire logic [asc_pkg::DATA_W-1:0] dq_in,
    output asc_pkg::asc_pins_t pins
);
    // The settle counter is CNT_W bits wide, so a longer wait cannot be loaded.
    if (SETTLE_CYC < 1 || SETTLE_CYC >= (1 << asc_pkg::CNT_W)) begin : g_settle_bad
        $error("SETTLE_CYC out of range");
    end

    typedef struct packed {
        asc_pkg::asc_state_t st;
        logic [asc_pkg::CNT_W-1:0] cnt;
        asc_pkg::asc_pins_t pins;
        logic ready;
        logic rvalid;
        logic [asc_pkg::DATA_W-1:0] rdata;
        logic [asc_pkg::DATA_W-1:0] s1;
        logic [asc_pkg::DATA_W-1:0] s2;
        logic [asc_pkg::DATA_W-1:0] s3;
        logic ret;
    } asc_regs_t;

    asc_regs_t cur_ff;
    asc_regs_t nxt_ff;

    function automatic asc_pkg::asc_pins_t idle_pins(input asc_pkg::asc_pins_t p);
        asc_pkg::asc_pins_t r;
        r = p;
        r.chip_select_n = 1'b1;
        r.write_strobe_n = 1'b1;
        r.output_drive_n = 1'b1;
        r.low_byte_sel_n = asc_pkg::BYTE_SEL_RST[0];
        r.high_byte_sel_n = asc_pkg::BYTE_SEL_RST[1];
        r.dq_oe = 1'b0;
        return r;
    endfunction

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.rvalid = 1'b0;
        nxt_ff.s1 = dq_in;
        nxt_ff.s2 = cur_ff.s1;
        nxt_ff.s3 = cur_ff.s2;
        if (cur_ff.cnt != '0) begin
            nxt_ff.cnt = cur_ff.cnt - 1'b1;
        end
        unique case (cur_ff.st)
            asc_pkg::ASC_POWERUP: begin
                if (cur_ff.cnt == '0) begin
                    nxt_ff.st = asc_pkg::ASC_IDLE;
                    nxt_ff.ready = 1'b1;
                end
            end
            asc_pkg::ASC_IDLE: begin
                nxt_ff.pins = idle_pins(cur_ff.pins);
                if (retention_req) begin
                    nxt_ff.ready = 1'b0;
                    nxt_ff.ret = 1'b1;
                    // A one-cycle request still gets the full recovery wait.
                    nxt_ff.cnt = asc_pkg::CNT_W'(asc_pkg::READ_CYCLE_CYC);
                    nxt_ff.st = asc_pkg::ASC_RECOVER;
                end else if (req_valid) begin
                    nxt_ff.ready = 1'b0;
                    nxt_ff.pins.addr = req.addr;
                    nxt_ff.pins.low_byte_sel_n = ~req.byte_en[0];
                    nxt_ff.pins.high_byte_sel_n = ~req.byte_en[1];
                    if (req.write) begin
                        // Data is driven while output drive stays high.
                        nxt_ff.pins.dq_out = req.wdata;
                        nxt_ff.pins.dq_oe = 1'b1;
                        nxt_ff.st = asc_pkg::ASC_WR_SETUP;
                    end else begin
                        nxt_ff.st = asc_pkg::ASC_RD_ADDR;
                    end
                end
            end
            asc_pkg::ASC_WR_SETUP: begin
                nxt_ff.pins.chip_select_n = 1'b0;
                nxt_ff.pins.write_strobe_n = 1'b0;
                nxt_ff.cnt = asc_pkg::CNT_W'(asc_pkg::WE_PULSE_CYC - 1);
                nxt_ff.st = asc_pkg::ASC_WR_PULSE;
            end
            asc_pkg::ASC_WR_PULSE: begin
                if (cur_ff.cnt == '0) begin
                    // Strobe alone ends the window; address and bytes hold a cycle more.
                    nxt_ff.pins.write_strobe_n = 1'b1;
                    nxt_ff.st = asc_pkg::ASC_WR_END;
                end
            end
            asc_pkg::ASC_WR_END: begin
                // Select and data drop only after the strobe is high.
                nxt_ff.pins = idle_pins(cur_ff.pins);
                nxt_ff.rvalid = 1'b1;
                nxt_ff.ready = 1'b1;
                nxt_ff.st = asc_pkg::ASC_IDLE;
            end
            asc_pkg::ASC_RD_ADDR: begin
                // Three-stage sampling adds latency on top of the access time.
                nxt_ff.pins.chip_select_n = 1'b0;
                nxt_ff.pins.output_drive_n = 1'b0;
                nxt_ff.cnt = asc_pkg::CNT_W'(asc_pkg::ACCESS_CYC + 2);
                nxt_ff.st = asc_pkg::ASC_RD_WAIT;
            end
            asc_pkg::ASC_RD_WAIT: begin
                // The bus value is taken only once the last two sampling stages agree.
                if (cur_ff.cnt == '0 && cur_ff.s2 == cur_ff.s3) begin
                    nxt_ff.rdata = cur_ff.s3;
                    nxt_ff.rvalid = 1'b1;
                    nxt_ff.pins = idle_pins(cur_ff.pins);
                    nxt_ff.ready = 1'b1;
                    nxt_ff.st = asc_pkg::ASC_IDLE;
                end
            end
            asc_pkg::ASC_RECOVER: begin
                nxt_ff.pins = idle_pins(cur_ff.pins);
                if (retention_req) begin
                    nxt_ff.cnt = asc_pkg::CNT_W'(asc_pkg::READ_CYCLE_CYC);
                end else if (cur_ff.cnt == '0) begin
                    nxt_ff.ret = 1'b0;
                    nxt_ff.ready = 1'b1;
                    nxt_ff.st = asc_pkg::ASC_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // Strobes park high so the memory sees no access while the supply settles.
            cur_ff <= '0;
            cur_ff.st <= asc_pkg::ASC_POWERUP;
            cur_ff.cnt <= asc_pkg::CNT_W'(SETTLE_CYC);
            cur_ff.pins.chip_select_n <= 1'b1;
            cur_ff.pins.write_strobe_n <= 1'b1;
            cur_ff.pins.output_drive_n <= 1'b1;
            cur_ff.pins.low_byte_sel_n <= 1'b1;
            cur_ff.pins.high_byte_sel_n <= 1'b1;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    assign pins = cur_ff.pins;
    assign req_ready = cur_ff.ready;
    assign rsp_valid = cur_ff.rvalid;
    assign rsp_rdata = cur_ff.rdata;
    assign in_retention = cur_ff.ret;

    // Pin protocol checks, all sampled on the controller clock.
    no_contention_a: assert property (@(posedge ref_clk) disable iff (rst)
        !(pins.dq_oe && !pins.output_drive_n)) else $error("data driven with output enabled");
    write_only_cs_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pins.write_strobe_n |-> !pins.chip_select_n) else $error("strobe without select");
    read_strobe_high_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pins.output_drive_n |-> pins.write_strobe_n) else $error("strobe low in read");
    settle_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        (cur_ff.st == asc_pkg::ASC_POWERUP) |-> pins.chip_select_n) else $error("access before settle");
    addr_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
        !pins.write_strobe_n |=> $stable(pins.addr) &&
            $stable(pins.low_byte_sel_n) && $stable(pins.high_byte_sel_n))
        else $error("address moved in write");
    strobe_first_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pins.write_strobe_n) |-> !pins.chip_select_n && pins.dq_oe)
        else $error("write not ended by strobe");
    strobe_setup_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pins.write_strobe_n) |-> !pins.chip_select_n && pins.dq_oe && pins.output_drive_n)
        else $error("strobe before select or data");
    data_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(pins.write_strobe_n) |-> $stable(pins.dq_out))
        else $error("write data moved at strobe end");
    idle_quiet_a: assert property (@(posedge ref_clk) disable iff (rst)
        req_ready |-> pins.chip_select_n && !pins.dq_oe)
        else $error("pins active while idle");
    pwr_no_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
        (cur_ff.st == asc_pkg::ASC_POWERUP) |-> !req_ready)
        else $error("ready before settle");
    ret_no_ready_a: assert property (@(posedge ref_clk) disable iff (rst)
        in_retention |-> !req_ready)
        else $error("ready in retention");
    recover_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(in_retention) |-> $past(in_retention, 2))
        else $error("recovery too short");
    read_lanes_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pins.output_drive_n) |-> $stable(pins.low_byte_sel_n) && $stable(pins.high_byte_sel_n))
        else $error("byte selects late");
    retain_desel_a: assert property (@(posedge ref_clk) disable iff (rst)
        in_retention |-> pins.chip_select_n) else $error("selected in retention");
    read_addr_first_a: assert property (@(posedge ref_clk) disable iff (rst)
        $fell(pins.chip_select_n) |-> $stable(pins.addr)) else $error("address late");
    wr_pulse_cov: cover property (@(posedge ref_clk) disable iff (rst) $fell(pins.write_strobe_n));
    rd_cov: cover property (@(posedge ref_clk) disable iff (rst) $fell(pins.output_drive_n));
    ret_cov: cover property (@(posedge ref_clk) disable iff (rst) $fell(in_retention));
    low_lane_cov: cover property (@(posedge ref_clk) disable iff (rst)
        $fell(pins.write_strobe_n) && pins.high_byte_sel_n);
endmodule

// *** dv/asc_sram_model.sv ***
`timescale 1ns/10ps
module asc_sram_model (
    input wire asc_pkg::asc_pins_t pins,
    output logic [15:0] dq_bus
);
    logic [15:0] mem [0:65535];
    logic [15:0] last = 16'h0000;
    logic [15:0] wa = 16'h0000;
    logic [15:0] wd = 16'h0000;
    logic [1:0] wl = 2'h0;
    logic [1:0] cur;
    logic [1:0] rd;
    // A released lane shows the inverse of its last level, so a stale value never passes for read data.
    always @(pins) begin
        cur = (!pins.chip_select_n && !pins.write_strobe_n) ? ~{pins.high_byte_sel_n, pins.low_byte_sel_n} : 2'h0;
        for (int i = 0; i < 2; i++) begin
            if (wl[i] && !cur[i]) begin
                mem[wa][i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        if (cur != 2'h0) begin
            wa = pins.addr;
            wd = pins.dq_oe ? pins.dq_out : ~last;
        end
        wl = cur;
        rd = (!pins.chip_select_n && !pins.output_drive_n && pins.write_strobe_n) ?
            ~{pins.high_byte_sel_n, pins.low_byte_sel_n} : 2'h0;
        for (int i = 0; i < 2; i++) begin
            dq_bus[i*8 +: 8] = pins.dq_oe ? pins.dq_out[i*8 +: 8] :
                rd[i] ? mem[pins.addr][i*8 +: 8] : ~last[i*8 +: 8];
        end
        last = dq_bus;
    end
endmodule

// *** dv/testbench.sv ***
`timescale 1ns/10ps
module testbench;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    asc_pkg::asc_req_t req = '0;
    logic retention_req = 1'b0;
    logic req_ready, rsp_valid, in_retention;
    logic [15:0] rsp_rdata, dq_bus, q;
    asc_pkg::asc_pins_t pins;
    int n_fail = 0;
    int compares = 0;
    localparam int SETTLE = 10;
    always #10 ref_clk = ~ref_clk;
    asc_ctrl #(.SETTLE_CYC(SETTLE)) asc_ctrl_inst (.ref_clk(ref_clk), .rst(rst), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .retention_req(retention_req),
        .in_retention(in_retention), .dq_in(dq_bus), .pins(pins));
    asc_sram_model asc_sram_model_inst (.pins(pins), .dq_bus(dq_bus));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Entered at a falling edge; request is held until the edge that takes it.
    task automatic op(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
        int n;
        n = 0;
        req = '{addr: a, wdata: d, byte_en: be, write: wr};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 1;
        while (rsp_valid !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        check(n, wr ? 4 : 6);
        q = rsp_rdata;
    endtask
    always @(negedge ref_clk) begin
        if (!rst && pins.output_drive_n === 1'b0) begin
            check({pins.dq_oe, pins.write_strobe_n}, 2'h1);
        end
    end
    // Entered at the falling edge that releases reset; counts cycles until ready.
    task automatic t_powerup();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge ref_clk);
            n++;
            if (n < SETTLE) begin
                check({req_ready, pins.chip_select_n}, 2'h1);
            end
        end
        check(n >= SETTLE, 1'b1);
        check(req_ready, 1'b1);
        $display("test powerup done");
    endtask
    task automatic t_reset();
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({req_ready, rsp_valid, pins.chip_select_n, pins.write_strobe_n, pins.output_drive_n, pins.dq_oe},
            6'h0e);
        rst = 1'b0;
        t_powerup();
        op(1'b0, 16'h0010, 16'h0000, 2'h3);
        check(q, 16'hcdab);
        $display("test mid-run reset done");
    endtask
    task automatic t_full();
        op(1'b1, 16'hffff, 16'ha5c3, 2'h3);
        op(1'b1, 16'h0000, 16'h5a3c, 2'h3);
        op(1'b0, 16'hffff, 16'h0000, 2'h3);
        check(q, 16'ha5c3);
        op(1'b0, 16'h0000, 16'h0000, 2'h3);
        check(q, 16'h5a3c);
        $display("test full words done");
    endtask
    task automatic t_lanes();
        op(1'b1, 16'h0010, 16'h1234, 2'h3);
        op(1'b1, 16'h0010, 16'h00ab, 2'h1);
        op(1'b1, 16'h0010, 16'hcd00, 2'h2);
        op(1'b0, 16'h0010, 16'h0000, 2'h1);
        check(q[7:0], 8'hab);
        op(1'b0, 16'h0010, 16'h0000, 2'h2);
        check(q[15:8], 8'hcd);
        $display("test byte lanes done");
    endtask
    task automatic t_retention();
        retention_req = 1'b1;
        repeat (3) @(negedge ref_clk);
        check({in_retention, pins.chip_select_n, req_ready}, 3'h6);
        retention_req = 1'b0;
        op(1'b0, 16'h0010, 16'h0000, 2'h3);
        check(q, 16'hcdab);
        $display("test retention done");
    endtask
    initial begin
        #200000;
        n_fail++;
        summarize();
    end
    initial begin
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        t_powerup();
        t_full();
        t_lanes();
        t_retention();
        t_reset();
        summarize();
    end
endmodule
